// ===== logic/pcmcs_params.svh
`ifndef PCMCS_PARAMS_SVH
`define PCMCS_PARAMS_SVH
`define PCMCS_CLK_HZ 40000000
`define PCMCS_SEQ_HZ 128000
`define PCMCS_FRAME_HZ 8000
`define PCMCS_SEQ_PER_FRAME 16
`define PCMCS_WORD_BITS 8
`define PCMCS_LIN_BITS 13
`define PCMCS_MU_BIAS 13'h0010
`define PCMCS_SIGN_POS 7
`define PCMCS_CHORD_MSB 6
`define PCMCS_CHORD_LSB 4
`define PCMCS_STEP_MSB 3
`define PCMCS_STEP_LSB 0
`define PCMCS_MAX_CHORD 3'h7
`define PCMCS_A_INVERT 8'h55
`define PCMCS_MU_INVERT 8'h7f
`define PCMCS_ZERO_SUPP 8'h02
`define PCMCS_FS_2V50 2'h1
`define PCMCS_FS_3V15 2'h0
`define PCMCS_FS_3V78 2'h2
`define PCMCS_RATE_TOL 16'h0010
`endif

// ===== logic/pcmcs_pkg.sv
package pcmcs_pkg;
	typedef enum logic [1:0]
	{
		PCMCS_LAW_MU_ZS = 2'h2,
		PCMCS_LAW_MU_SM = 2'h1,
		PCMCS_LAW_A     = 2'h0
	} pcmcs_law_t;
	typedef enum logic [2:0]
	{
		PCMCS_RATE_NONE = 3'h0,
		PCMCS_RATE_128K = 3'h1,
		PCMCS_RATE_1536 = 3'h2,
		PCMCS_RATE_1544 = 3'h3,
		PCMCS_RATE_2048 = 3'h4,
		PCMCS_RATE_2560 = 3'h5
	} pcmcs_rate_t;
endpackage : pcmcs_pkg

// ===== logic/pcmcs_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcmcs_params.svh"
module pcmcs_encoder
	import pcmcs_pkg::*;
(
	// Sample in
	input  wire logic [12:0] lin_in,
	input  wire pcmcs_law_t  law_in,
	// Word out
	output logic      [7:0]  word_out
);
	logic [12:0] mag;
	logic [12:0] biased;
	logic [2:0]  chord;
	logic [3:0]  step;
	logic [7:0]  raw;
	always_comb
	begin
		mag    = lin_in[12] ? 13'((~lin_in) + 13'h0001) : lin_in;
		// Clamp to twelve magnitude bits so full scale saturates
		if (law_in == PCMCS_LAW_A)
			biased = (mag > 13'h0fff) ? 13'h0fff : mag;
		else
			biased = (mag > 13'h0fef) ? 13'h0fff : 13'(mag + `PCMCS_MU_BIAS);
		chord  = 3'h0;
		// Chord is position of leading one, each chord doubles step weight except A-law chord one
		for (int i = 0; i < 7; i++)
			if (biased[i + 5])
				chord = 3'(i + 1);
		// Mu chord zero sits just under the bias bit, half the chord one weight
		if (law_in == PCMCS_LAW_A && chord == 3'h0)
			step = biased[4:1];
		else
			step = 4'(biased >> chord);
		raw = {~lin_in[12], chord, step};
		unique case (law_in)
			PCMCS_LAW_MU_ZS:
				word_out = ((raw ^ `PCMCS_MU_INVERT) == 8'h00) ? `PCMCS_ZERO_SUPP
					: raw ^ `PCMCS_MU_INVERT;
			PCMCS_LAW_MU_SM:
				word_out = raw;
			default:
				word_out = raw ^ `PCMCS_A_INVERT;
		endcase
	end
endmodule : pcmcs_encoder
`default_nettype wire

// ===== logic/pcmcs_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcmcs_params.svh"
module pcmcs_decoder
	import pcmcs_pkg::*;
(
	// Word in
	input  wire logic [7:0]  word_in,
	input  wire pcmcs_law_t  law_in,
	// Sample out
	output logic      [12:0] lin_out
);
	logic [7:0]  raw;
	logic [12:0] mag;
	always_comb
	begin
		unique case (law_in)
			PCMCS_LAW_MU_ZS:
				raw = word_in ^ `PCMCS_MU_INVERT;
			PCMCS_LAW_MU_SM:
				raw = word_in;
			default:
				raw = word_in ^ `PCMCS_A_INVERT;
		endcase
		// Step weight doubles per chord except A-law chord one, mid-step reconstruction
		if (law_in != PCMCS_LAW_A)
			mag = 13'((({8'h00, 1'b1, raw[3:0], 1'b1} << raw[6:4]) >> 1) - `PCMCS_MU_BIAS);
		else if (raw[6:4] == 3'h0)
			mag = {8'h00, raw[3:0], 1'b1};
		else
			mag = 13'({8'h00, 1'b1, raw[3:0], 1'b1} << (raw[6:4] - 3'h1));
		lin_out = raw[7] ? mag : 13'((~mag) + 13'h0001);
	end
endmodule : pcmcs_decoder
`default_nettype wire

// ===== logic/pcmcs_top.sv
// Overview of operation
// - Samples are 8-bit words: sign, three chord, four step bits from 13-bit linear.
// - All sixteen steps within one chord carry equal weight.
// - Steps carry into chord; each chord step doubles the step weight, except A-law chord one, which keeps chord zero's weight.
// - Seven chords above zero, each spanning a factor of two.
// - Mu-255 or A-law chosen by the law select input.
// - One sample per 8 kHz frame, frame sync supplied by controller.
// - Reduced-pin variant uses the shared bit clock as transmit clock; convert clock stays separate.
// - Full variant: standard convert rate, data clocks 64 kHz to 4.096 MHz.
// - Full variant accepts bit and byte interleaved time slots.
// - Three-level full-scale select picks 2.5, 3.15 or 3.78 volt peak.
// - Convert clock measured against frame sync picks divider for 128 kHz sequencing.
// - First window rise after frame sync loads word; window-gated clock shifts bits.
// - Receive: sign on first falling edge, seven more, transfer at ninth rise.
// - Three-level law select: mu zero-suppress, mu sign-magnitude, A-law inverted.
`timescale 1ns/1ps
`default_nettype none
`include "pcmcs_params.svh"
module pcmcs_top
	import pcmcs_pkg::*;
#(
	parameter bit REDUCED_PIN = 1'b0
)
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// Timing pins
	input  wire logic        convert_clock_in,
	input  wire logic        frame_sync_in,
	input  wire logic        shared_bit_clock_in,
	// Transmit pins
	input  wire logic        tx_bit_clock_in,
	input  wire logic        tx_window_enable_in,
	output logic             tx_serial_out,
	output logic             tx_serial_oe_n_out,
	// Receive pins
	input  wire logic        rx_bit_clock_in,
	input  wire logic        rx_word_enable_in,
	input  wire logic        rx_serial_in,
	// Selects
	input  wire logic [1:0]  law_select_in,
	input  wire logic [1:0]  fullscale_select_in,
	// Converter side
	input  wire logic [12:0] adc_sample_in,
	output logic             adc_start_out,
	output logic      [12:0] dac_sample_out,
	output logic             dac_load_out,
	output logic             seq_tick_out,
	output logic      [2:0]  rate_out,
	output logic      [1:0]  fullscale_out
);
	// Sync stages, first stage read only by second
	logic [6:0] s1_reg;
	logic [6:0] s2_reg;
	logic [6:0] s3_reg;
	logic [6:0] raw_pins;
	assign raw_pins = {convert_clock_in, frame_sync_in, shared_bit_clock_in, tx_bit_clock_in,
		tx_window_enable_in, rx_bit_clock_in, rx_word_enable_in};
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			s1_reg <= 7'h00;
			s2_reg <= 7'h00;
			s3_reg <= 7'h00;
		end
		else
		begin
			s1_reg <= raw_pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	logic rxd1_reg;
	logic rxd2_reg;
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			rxd1_reg <= 1'b0;
			rxd2_reg <= 1'b0;
		end
		else
		begin
			rxd1_reg <= rx_serial_in;
			rxd2_reg <= rxd1_reg;
		end
	end
	logic cc_rise;
	logic fs_rise;
	logic txc_now;
	logic txc_prev;
	logic txc_rise;
	logic txw;
	logic txw_rise;
	logic rxc_rise;
	logic rxc_fall;
	logic rxe_rise;
	assign cc_rise  = s2_reg[6] & ~s3_reg[6];
	assign fs_rise  = s2_reg[5] & ~s3_reg[5];
	// Reduced-pin variant: shared bit clock serves transmit, convert keeps its own clock
	assign txc_now  = REDUCED_PIN ? s2_reg[4] : s2_reg[3];
	assign txc_prev = REDUCED_PIN ? s3_reg[4] : s3_reg[3];
	assign txc_rise = txc_now & ~txc_prev;
	assign txw      = s2_reg[2];
	assign txw_rise = s2_reg[2] & ~s3_reg[2];
	assign rxc_rise = s2_reg[1] & ~s3_reg[1];
	assign rxc_fall = ~s2_reg[1] & s3_reg[1];
	assign rxe_rise = s2_reg[0] & ~s3_reg[0];
	// Convert clock rate measurement per frame
	logic [15:0]  cc_cnt_reg;
	logic [15:0]  ccps_reg;
	pcmcs_rate_t  rate_reg;
	logic [15:0]  div_reg;
	function automatic logic in_band(input logic [15:0] n, input logic [15:0] nom);
		in_band = (n + `PCMCS_RATE_TOL >= nom) && (n <= nom + `PCMCS_RATE_TOL);
	endfunction : in_band
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			cc_cnt_reg <= 16'h0000;
			rate_reg   <= PCMCS_RATE_NONE;
			div_reg    <= 16'h0000;
		end
		else if (fs_rise)
		begin
			cc_cnt_reg <= 16'h0000;
			// Edges per 8 kHz frame pick the prescaler
			if (in_band(cc_cnt_reg, 16'h0010))
			begin
				rate_reg <= PCMCS_RATE_128K;
				div_reg  <= 16'h0001;
			end
			else if (in_band(cc_cnt_reg, 16'h00c0) && cc_cnt_reg <= 16'h00c0)
			begin
				rate_reg <= PCMCS_RATE_1536;
				div_reg  <= 16'h000c;
			end
			else if (in_band(cc_cnt_reg, 16'h00c1))
			begin
				rate_reg <= PCMCS_RATE_1544;
				div_reg  <= 16'h000c;
			end
			else if (in_band(cc_cnt_reg, 16'h0100))
			begin
				rate_reg <= PCMCS_RATE_2048;
				div_reg  <= 16'h0010;
			end
			else if (in_band(cc_cnt_reg, 16'h0140))
			begin
				rate_reg <= PCMCS_RATE_2560;
				div_reg  <= 16'h0014;
			end
			else
			begin
				rate_reg <= PCMCS_RATE_NONE;
				div_reg  <= 16'h0000;
			end
		end
		else if (cc_rise && cc_cnt_reg != 16'hffff)
			cc_cnt_reg <= cc_cnt_reg + 16'h0001;
	end
	// Prescaler to 16 sequencing ticks per frame; 1544 drops extra edge by restart
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			ccps_reg     <= 16'h0000;
			seq_tick_out <= 1'b0;
		end
		else
		begin
			seq_tick_out <= 1'b0;
			if (fs_rise)
				ccps_reg <= 16'h0000;
			else if (cc_rise && div_reg != 16'h0000)
			begin
				if (ccps_reg + 16'h0001 >= div_reg)
				begin
					ccps_reg     <= 16'h0000;
					seq_tick_out <= 1'b1;
				end
				else
					ccps_reg <= ccps_reg + 16'h0001;
			end
		end
	end
	// Transmit: armed by frame sync, strobe on first window rise
	logic       armed_reg;
	logic [7:0] tx_shift_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] enc_word;
	pcmcs_law_t law;
	assign law = pcmcs_law_t'(law_select_in);
	pcmcs_encoder u_enc
	(
		.lin_in   (adc_sample_in),
		.law_in   (law),
		.word_out (enc_word)
	);
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			armed_reg     <= 1'b0;
			adc_start_out <= 1'b0;
			tx_shift_reg  <= 8'h00;
			tx_bit_reg    <= 3'h0;
		end
		else
		begin
			adc_start_out <= 1'b0;
			if (fs_rise)
				armed_reg <= 1'b1;
			if (txw_rise && armed_reg && !fs_rise)
			begin
				armed_reg     <= 1'b0;
				adc_start_out <= 1'b1;
				tx_shift_reg  <= enc_word;
				tx_bit_reg    <= 3'h0;
			end
			else if (txw && txc_rise)
			begin
				// Recirculate so word can be read again; bit or byte slots
				tx_shift_reg <= {tx_shift_reg[6:0], tx_shift_reg[7]};
				tx_bit_reg   <= tx_bit_reg + 3'h1;
			end
		end
	end
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			tx_serial_out      <= 1'b0;
			tx_serial_oe_n_out <= 1'b1;
		end
		else
		begin
			tx_serial_out      <= tx_shift_reg[7];
			tx_serial_oe_n_out <= ~txw;
		end
	end
	// Receive shift on falling clock, transfer on ninth rise
	logic [7:0]  rx_shift_reg;
	logic [3:0]  rx_fall_reg;
	logic [3:0]  rx_rise_reg;
	logic        rx_act_reg;
	logic [7:0]  rx_word_reg;
	logic        rx_go_reg;
	logic [12:0] dec_lin;
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			rx_shift_reg <= 8'h00;
			rx_fall_reg  <= 4'h0;
			rx_rise_reg  <= 4'h0;
			rx_act_reg   <= 1'b0;
			rx_word_reg  <= 8'h00;
			rx_go_reg    <= 1'b0;
		end
		else
		begin
			rx_go_reg <= 1'b0;
			if (rxe_rise)
			begin
				rx_act_reg  <= 1'b1;
				rx_fall_reg <= 4'h0;
				rx_rise_reg <= 4'h0;
			end
			else if (rx_act_reg)
			begin
				if (rxc_fall && rx_fall_reg < 4'h8)
				begin
					rx_shift_reg <= {rx_shift_reg[6:0], rxd2_reg};
					rx_fall_reg  <= rx_fall_reg + 4'h1;
				end
				if (rxc_rise)
				begin
					rx_rise_reg <= rx_rise_reg + 4'h1;
					if (rx_rise_reg == 4'h8)
					begin
						rx_word_reg <= rx_shift_reg;
						rx_go_reg   <= 1'b1;
						rx_act_reg  <= 1'b0;
					end
				end
			end
		end
	end
	pcmcs_decoder u_dec
	(
		.word_in (rx_word_reg),
		.law_in  (law),
		.lin_out (dec_lin)
	);
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			dac_sample_out <= 13'h0000;
			dac_load_out   <= 1'b0;
			rate_out       <= 3'h0;
			fullscale_out  <= `PCMCS_FS_3V15;
		end
		else
		begin
			dac_load_out <= rx_go_reg;
			if (rx_go_reg)
				dac_sample_out <= dec_lin;
			rate_out      <= rate_reg;
			fullscale_out <= fullscale_select_in;
		end
	end
	frame_tick_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		adc_start_out |-> !$past(adc_start_out)) else $error("Start not single pulse");
	oe_follow_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		txw |=> !tx_serial_oe_n_out) else $error("Output not enabled");
	oe_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!txw |=> tx_serial_oe_n_out) else $error("Output not floated");
	load_bit_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		adc_start_out |-> tx_bit_reg == 3'h0) else $error("Bit count not reset");
	rx_xfer_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		rx_go_reg |=> dac_load_out && dac_sample_out == $past(dec_lin)) else $error("Bad transfer");
	rx_count_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		rx_go_reg |-> rx_fall_reg == 4'h8) else $error("Transfer before eight bits");
	rate_div_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		rate_reg == PCMCS_RATE_2048 |-> div_reg == 16'h0010) else $error("Wrong divider");
	fs_pass_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		1'b1 |=> fullscale_out == $past(fullscale_select_in)) else $error("Full scale lag");
	no_rate_tick_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		div_reg == 16'h0000 |=> !seq_tick_out) else $error("Tick without rate");
endmodule : pcmcs_top
`default_nettype wire

// ===== test/pcmcs_highway.sv
`timescale 1ns/1ps
`default_nettype none
module pcmcs_highway
(
	// Clock and observed pins
	input  wire logic clk_in,
	input  wire logic tx_data_in,
	input  wire logic tx_oe_n_in,
	// Driven pins
	output var logic  convert_clock_out,
	output var logic  frame_sync_out,
	output var logic  tx_bit_clock_out,
	output var logic  tx_window_enable_out,
	output var logic  rx_bit_clock_out,
	output var logic  rx_word_enable_out,
	output var logic  rx_serial_out
);
	int cc_khz = 2048;
	int acc    = 0;
	int fcnt   = 0;
	initial
	begin
		{convert_clock_out, frame_sync_out, tx_bit_clock_out} = 3'h0;
		{tx_window_enable_out, rx_bit_clock_out} = 2'h0;
		{rx_word_enable_out, rx_serial_out} = 2'h0;
	end
	// Frame sync square wave and convert clock accumulator
	always @(negedge clk_in)
	begin
		fcnt = (fcnt == 4999) ? 0 : fcnt + 1;
		frame_sync_out = (fcnt < 2500);
		acc = acc + cc_khz * 50;
		if (acc >= 1000000)
		begin
			acc = acc - 1000000;
			convert_clock_out = ~convert_clock_out;
		end
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clk_in);
	endtask : idle
	// One word out, optional window gaps between bits
	task automatic tx_byte(input bit il, output logic [8:0] b, output logic gap);
		gap = 1'b1;
		@(negedge clk_in);
		tx_window_enable_out = 1'b1;
		idle(10);
		for (int i = 8; i >= 0; i--)
		begin
			b[i] = tx_data_in;
			if (i > 0)
			begin
				tx_bit_clock_out = 1'b1;
				idle(8);
				tx_bit_clock_out = 1'b0;
				if (il)
				begin
					tx_window_enable_out = 1'b0;
					idle(8);
					gap = gap & tx_oe_n_in;
					tx_window_enable_out = 1'b1;
				end
				idle(8);
			end
		end
		tx_window_enable_out = 1'b0;
	endtask : tx_byte
	// One word in, data line inverted once hold has run out
	task automatic rx_byte(input logic [7:0] w);
		@(negedge clk_in);
		rx_word_enable_out = 1'b1;
		for (int i = 8; i >= 0; i--)
		begin
			if (i > 0)
				rx_serial_out = w[i - 1];
			idle(8);
			rx_bit_clock_out = 1'b1;
			idle(8);
			rx_bit_clock_out = 1'b0;
			idle(5);
			rx_serial_out = ~rx_serial_out;
			idle(3);
		end
		rx_word_enable_out = 1'b0;
		idle(4);
	endtask : rx_byte
endmodule : pcmcs_highway
`default_nettype wire

// ===== test/tb_pcmcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pcmcs_top;
	logic        clk_in, reset_n_in, cc, fs, txc, txw, rxc, rxe, rxd;
	logic        txd, oe_n, st, dl, tick;
	logic [1:0]  law, fsel, fs_out;
	logic [2:0]  rate;
	logic [12:0] adc, dac;
	int          fail_count = 0;
	int          n_checks = 0;
	int          starts = 0;
	int          ticks = 0;
	int          loads = 0;
	pcmcs_top dut
	(
		.clk_in(clk_in), .reset_n_in(reset_n_in),
		.convert_clock_in(cc), .frame_sync_in(fs), .shared_bit_clock_in(txc),
		.tx_bit_clock_in(txc), .tx_window_enable_in(txw),
		.tx_serial_out(txd), .tx_serial_oe_n_out(oe_n),
		.rx_bit_clock_in(rxc), .rx_word_enable_in(rxe), .rx_serial_in(rxd),
		.law_select_in(law), .fullscale_select_in(fsel),
		.adc_sample_in(adc), .adc_start_out(st), .dac_sample_out(dac),
		.dac_load_out(dl), .seq_tick_out(tick), .rate_out(rate),
		.fullscale_out(fs_out)
	);
	pcmcs_highway hw
	(
		.clk_in(clk_in), .tx_data_in(txd), .tx_oe_n_in(oe_n),
		.convert_clock_out(cc), .frame_sync_out(fs), .tx_bit_clock_out(txc),
		.tx_window_enable_out(txw), .rx_bit_clock_out(rxc),
		.rx_word_enable_out(rxe), .rx_serial_out(rxd)
	);
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Pulse counters
	always @(posedge clk_in)
	begin
		starts <= starts + int'(st === 1'b1);
		ticks <= ticks + int'(tick === 1'b1);
		loads <= loads + int'(dl === 1'b1);
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task automatic rx_dec(input logic [1:0] lw, input logic [7:0] w, output logic [12:0] d);
		int l0;
		@(negedge clk_in);
		law = lw;
		l0 = loads;
		hw.rx_byte(w);
		for (int k = 0; k < 40 && loads == l0; k++)
			@(negedge clk_in);
		check("rx load", 16'h1, 16'(loads - l0));
		d = dac;
	endtask : rx_dec
	task automatic t_reset;
		check("oe_n", 16'h1, 16'(oe_n));
		check("start", 16'h0, 16'(st));
		check("rate", 16'h0, 16'(rate));
		$display("test reset done");
	endtask : t_reset
	task automatic t_fullscale;
		logic [1:0] v [3] = '{2'h1, 2'h0, 2'h2};
		for (int i = 0; i < 3; i++)
		begin
			fsel = v[i];
			hw.idle(6);
			check("fullscale", 16'(v[i]), 16'(fs_out));
		end
		$display("test fullscale done");
	endtask : t_fullscale
	task automatic t_tx;
		logic [1:0] lw [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
		logic [7:0] ex [6] = '{8'hff, 8'h7f, 8'h80, 8'h02, 8'haa, 8'h2a};
		logic [8:0] b;
		logic       g;
		int         s0;
		for (int i = 0; i < 6; i++)
		begin
			law = lw[i];
			adc = i[0] ? 13'h1000 : 13'h0fff;
			@(posedge fs);
			s0 = starts;
			hw.tx_byte(i == 5, b, g);
			check("tx word", 16'(ex[i]), 16'(b[8:1]));
			check("tx recirc", 16'(ex[i][7]), 16'(b[0]));
			check("tx start", 16'h1, 16'(starts - s0));
			if (i == 5)
				check("tx gap oe_n", 16'h1, 16'(g));
			hw.idle(8);
			check("tx oe_n", 16'h1, 16'(oe_n));
		end
		$display("test tx done");
	endtask : t_tx
	task automatic t_rx_chords;
		logic signed [12:0] d0, d1, d14, d15;
		int                 stp, prev;
		prev = 0;
		for (int c = 0; c < 8; c++)
		begin
			rx_dec(2'h1, 8'h80 | 8'(c << 4), d0);
			rx_dec(2'h1, 8'h81 | 8'(c << 4), d1);
			rx_dec(2'h1, 8'h8e | 8'(c << 4), d14);
			rx_dec(2'h1, 8'h8f | 8'(c << 4), d15);
			stp = d1 - d0;
			check("step pos", 16'h1, 16'(stp > 0));
			check("step even", 16'(stp), 16'(d15 - d14));
			if (c > 0)
				check("step double", 16'(2 * prev), 16'(stp));
			prev = stp;
		end
		$display("test rx chords done");
	endtask : t_rx_chords
	task automatic t_rx_laws;
		logic signed [12:0] a, b;
		rx_dec(2'h1, 8'hff, a);
		rx_dec(2'h2, 8'h80, b);
		check("mu full", 16'(a), 16'(b));
		check("mu sign", 16'h0, 16'(a[12]));
		rx_dec(2'h1, 8'h7f, a);
		rx_dec(2'h2, 8'h00, b);
		check("mu neg full", 16'(a), 16'(b));
		rx_dec(2'h0, 8'haa, a);
		rx_dec(2'h0, 8'h2a, b);
		check("a sym", 16'(a), 16'(-b));
		check("a sign", 16'h0, 16'(a[12]));
		$display("test rx laws done");
	endtask : t_rx_laws
	task automatic t_rates;
		int         khz [5] = '{128, 1536, 1544, 2048, 2560};
		logic [2:0] ex [5] = '{3'h1, 3'h0, 3'h0, 3'h4, 3'h5};
		int         t0;
		@(posedge fs);
		for (int i = 0; i < 5; i++)
		begin
			hw.cc_khz = khz[i];
			@(posedge fs);
			t0 = ticks;
			@(posedge fs);
			if (ex[i] == 3'h0)
				check("rate", 16'h1, 16'(rate inside {3'h2, 3'h3}));
			else
				check("rate", 16'(ex[i]), 16'(rate));
			check("ticks", 16'h1, 16'((ticks - t0) inside {[15:17]}));
		end
		$display("test rates done");
	endtask : t_rates
	initial
	begin
		#3000000;
		fail_count++;
		$display("Error watchdog expected done seen timeout");
		tally_and_finish;
	end
	initial
	begin
		reset_n_in = 1'b0;
		law = 2'h1;
		fsel = 2'h0;
		adc = 13'h0;
		repeat (4) @(negedge clk_in);
		t_reset;
		reset_n_in = 1'b1;
		t_fullscale;
		t_tx;
		t_rx_chords;
		t_rx_laws;
		t_rates;
		tally_and_finish;
	end
endmodule : tb_pcmcs_top
`default_nettype wire
